// [design/sar_seq_defines.svh]
// constants for the conversion sequencer: field positions, reset values, timing
// assumes inclusion by bare name from the package and the sequencer module
`ifndef SAR_SEQ_DEFINES_SVH
`define SAR_SEQ_DEFINES_SVH

// ==========================================================================
// serial word layout
`define WORD_W 16
`define KIND_HI 15
`define KIND_LO 14
`define CTRL_START_BIT 0
`define CTRL_SEL_HI 2
`define CTRL_SEL_LO 1
`define TRIM_DATA_W 14
`define RESULT_W 12
`define STAT_BUSY_BIT 14
`define STAT_SELECT_ONES 16'h00c0

// ==========================================================================
// reset values
`define OFFSET_TRIM_RST 14'h2000
`define GAIN_TRIM_RST 14'h2000
`define TRIM_MID 15'sh2000
`define TRIM_SCALE 41'sh333

// ==========================================================================
// timing
`define MCLK_PERIOD_NS 20
`define START_SETUP_NS 10
`define START_SETUP_CYC ((`START_SETUP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CONV_HALVES_FAST 6'd33
`define CONV_HALVES_SLOW 6'd35
`define CONV_HALVES_MAX 6'd36
`define FIFO_DEPTH 8
`define SCLK_HALF_CYC 4

`endif

// [design/sar_seq_pkg.sv]
// shared types of the conversion sequencer
// assumes the defines header sits beside it
`include "sar_seq_defines.svh"

package sar_seq_pkg;
    // ==========================================================================
    // conversion states
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_WAIT = 2'b01,
        CV_RUN = 2'b10
    } conv_state_t;

    // ==========================================================================
    // what the next frame shifts out
    typedef enum logic [1:0] {
        RD_RESULT = 2'b00,
        RD_STATUS = 2'b01,
        RD_OFFSET = 2'b10,
        RD_GAIN = 2'b11
    } read_sel_t;

    // ==========================================================================
    // result word as it leaves the part
    typedef struct packed {
        logic [3:0] zeros;
        logic [11:0] code;
    } result_word_t;

    // ==========================================================================
    // filtered pin group
    typedef struct packed {
        logic mode_b;
        logic mode_a;
        logic din;
        logic sync;
        logic sclk;
        logic start_n;
        logic mclk_in;
    } pins_t;
endpackage : sar_seq_pkg

// [design/result_fifo.sv]
// result buffer between the converter and the serial port
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================================
    // storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule : result_fifo

`default_nettype wire

// [design/sar_conversion_sequencer_cal.sv]
// conversion sequencer with offset and gain trim and a serial result port
// assumes MCLK at 50 MHz; all pins from outside are asynchronous to it
// assumes ADC_CODE and CAL_IN_PROGRESS come from the analog core on MCLK
`timescale 1ns/10ps
`default_nettype none
`include "sar_seq_defines.svh"

module sar_conversion_sequencer_cal #(
    parameter int SCLK_HALF = `SCLK_HALF_CYC,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic MASTER_CLOCK_IN,
    input wire logic CONVERSION_START_N,
    input wire logic SERIAL_MODE_SEL_A,
    input wire logic SERIAL_MODE_SEL_B,
    input wire logic [11:0] ADC_CODE,
    input wire logic CAL_IN_PROGRESS,
    input wire logic SCLK_I,
    output logic SCLK_O,
    output logic SCLK_OE,
    input wire logic SYNC_I,
    output logic SYNC_O,
    output logic SYNC_OE,
    input wire logic DIN,
    output logic DOUT,
    output logic BUSY,
    output logic TRACK_HOLD
);
    // ==========================================================================
    // functions
    // trim arithmetic: top data bit is 5% of full scale on offset, 2.5% on gain
    function automatic logic [11:0] apply_trim(input logic [11:0] code,
                                               input logic [13:0] off,
                                               input logic [13:0] gn);
        logic signed [14:0] doff;
        logic signed [14:0] dgn;
        logic signed [40:0] sum;
        doff = $signed({1'b0, off}) - `TRIM_MID;
        dgn = $signed({1'b0, gn}) - `TRIM_MID;
        sum = $signed(41'(code));
        sum = sum + ((41'(doff) * `TRIM_SCALE) >>> 15);
        sum = sum + (($signed(41'(code)) * 41'(dgn) * `TRIM_SCALE) >>> 28);
        if (sum < 0) begin
            apply_trim = 12'h000;
        end else if (sum > 41'sd4095) begin
            apply_trim = 12'hfff;
        end else begin
            apply_trim = sum[11:0];
        end
    endfunction : apply_trim

    function automatic logic [5:0] halves_for(input logic setup_ok);
        logic [5:0] h;
        h = setup_ok ? `CONV_HALVES_FAST : `CONV_HALVES_SLOW;
        // a slow clock stall cannot stretch past the worst case
        halves_for = (h > `CONV_HALVES_MAX) ? `CONV_HALVES_MAX : h;
    endfunction : halves_for

    // ==========================================================================
    // pin synchronisers: three stages, a change counts once stages two and three agree
    sar_seq_pkg::pins_t raw;
    sar_seq_pkg::pins_t s1_q;
    sar_seq_pkg::pins_t s2_q;
    sar_seq_pkg::pins_t s3_q;
    sar_seq_pkg::pins_t f_q;
    sar_seq_pkg::pins_t fp_q;

    assign raw = '{mode_b: SERIAL_MODE_SEL_B, mode_a: SERIAL_MODE_SEL_A, din: DIN,
                   sync: SYNC_I, sclk: SCLK_I, start_n: CONVERSION_START_N,
                   mclk_in: MASTER_CLOCK_IN};

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s1_q <= 7'h7e;
            s2_q <= 7'h7e;
            s3_q <= 7'h7e;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            f_q <= 7'h7e;
            fp_q <= 7'h7e;
        end else begin
            f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
            fp_q <= f_q;
        end
    end

    logic mclk_fall;
    logic mclk_edge;
    logic start_rise;
    logic master_mode;

    assign mclk_fall = fp_q.mclk_in && !f_q.mclk_in;
    assign mclk_edge = fp_q.mclk_in != f_q.mclk_in;
    assign start_rise = !fp_q.start_n && f_q.start_n;
    assign master_mode = f_q.mode_a && f_q.mode_b;

    // ==========================================================================
    // trim and control registers
    logic [13:0] offset_trim_q;
    logic [13:0] gain_trim_q;
    logic start_bit_q;
    sar_seq_pkg::read_sel_t read_sel_q;
    logic wr_done;
    logic [15:0] rx_q;
    logic [1:0] kind;
    logic busy_fall;

    assign kind = rx_q[`KIND_HI:`KIND_LO];

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            offset_trim_q <= `OFFSET_TRIM_RST;
            gain_trim_q <= `GAIN_TRIM_RST;
        end else if (wr_done && kind == 2'b01) begin
            offset_trim_q <= rx_q[`TRIM_DATA_W-1:0];
        end else if (wr_done && kind == 2'b10) begin
            gain_trim_q <= rx_q[`TRIM_DATA_W-1:0];
        end
    end

    // a fresh write of one wins over the clear from a falling busy
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            start_bit_q <= 1'b0;
        end else if (wr_done && kind == 2'b00 && rx_q[`CTRL_START_BIT]) begin
            start_bit_q <= 1'b1;
        end else if (busy_fall) begin
            start_bit_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            read_sel_q <= sar_seq_pkg::RD_RESULT;
        end else if (wr_done && kind == 2'b00) begin
            read_sel_q <= sar_seq_pkg::read_sel_t'(rx_q[`CTRL_SEL_HI:`CTRL_SEL_LO]);
        end
    end

    // ==========================================================================
    // conversion sequencer
    sar_seq_pkg::conv_state_t state_q;
    logic [5:0] halves_q;
    logic [5:0] target_q;
    logic [3:0] since_q;
    logic launch;
    logic fifo_in_ready;
    logic push_q;
    logic [15:0] push_word_q;
    logic conv_end;

    // a full buffer refuses new starts so no result is ever dropped
    assign launch = state_q == sar_seq_pkg::CV_IDLE && fifo_in_ready && !push_q &&
                    (start_rise || (wr_done && kind == 2'b00 && rx_q[`CTRL_START_BIT]));
    assign conv_end = state_q == sar_seq_pkg::CV_RUN && mclk_edge &&
                      (halves_q + 6'd1 == target_q);
    assign busy_fall = conv_end;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_q <= sar_seq_pkg::CV_IDLE;
        end else begin
            case (state_q)
                sar_seq_pkg::CV_IDLE: begin
                    if (launch) begin
                        state_q <= sar_seq_pkg::CV_WAIT;
                    end
                end
                sar_seq_pkg::CV_WAIT: begin
                    if (mclk_fall) begin
                        state_q <= sar_seq_pkg::CV_RUN;
                    end
                end
                sar_seq_pkg::CV_RUN: begin
                    if (conv_end) begin
                        state_q <= sar_seq_pkg::CV_IDLE;
                    end
                end
                default: begin
                    state_q <= sar_seq_pkg::CV_IDLE;
                end
            endcase
        end
    end

    // setup is judged in MCLK cycles between the start and the clock fall
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            since_q <= 4'h0;
        end else if (launch) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            target_q <= `CONV_HALVES_SLOW;
            halves_q <= 6'h00;
        end else if (state_q == sar_seq_pkg::CV_WAIT && mclk_fall) begin
            target_q <= halves_for(32'(since_q) >= `START_SETUP_CYC);
            halves_q <= 6'h00;
        end else if (state_q == sar_seq_pkg::CV_RUN && mclk_edge) begin
            halves_q <= halves_q + 6'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            BUSY <= 1'b0;
        end else if (state_q == sar_seq_pkg::CV_WAIT && mclk_fall) begin
            BUSY <= 1'b1;
        end else if (conv_end) begin
            BUSY <= 1'b0;
        end
    end

    // sampler holds from the start until busy falls, then tracks again
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            TRACK_HOLD <= 1'b0;
        end else if (launch) begin
            TRACK_HOLD <= 1'b1;
        end else if (conv_end) begin
            TRACK_HOLD <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            push_q <= 1'b0;
            push_word_q <= 16'h0000;
        end else begin
            push_q <= conv_end;
            if (conv_end) begin
                push_word_q <= sar_seq_pkg::result_word_t'{zeros: 4'h0,
                                 code: apply_trim(ADC_CODE, offset_trim_q, gain_trim_q)};
            end
        end
    end

    // ==========================================================================
    // result buffer
    logic fifo_out_valid;
    logic fifo_pop;
    logic [15:0] fifo_out_data;

    result_fifo #(
        .WIDTH(`WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RST_N),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_word_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ==========================================================================
    // serial clock and sync generator, used only in master mode
    logic m_active_q;
    logic m_sclk_q;
    logic [4:0] m_falls_q;
    logic [7:0] m_div_q;
    logic m_tick;
    logic m_start;

    assign m_tick = m_active_q && (32'(m_div_q) == SCLK_HALF - 1);
    // master frames carry the word read_sel_q selects, sent as soon as the buffer holds a result
    assign m_start = master_mode && !m_active_q && fifo_out_valid;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            m_div_q <= 8'h00;
        end else if (!m_active_q || m_tick) begin
            m_div_q <= 8'h00;
        end else begin
            m_div_q <= m_div_q + 8'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            m_active_q <= 1'b0;
            m_sclk_q <= 1'b0;
            m_falls_q <= 5'h00;
        end else if (m_start) begin
            m_active_q <= 1'b1;
            m_sclk_q <= 1'b0;
            m_falls_q <= 5'h00;
        end else if (m_tick) begin
            m_sclk_q <= !m_sclk_q;
            if (m_sclk_q) begin
                m_falls_q <= m_falls_q + 5'h01;
                if (m_falls_q == 5'd15) begin
                    m_active_q <= 1'b0;
                end
            end
        end
    end

    // ==========================================================================
    // shared frame events from either the host pins or the generator
    logic frame_start;
    logic frame_end;
    logic bit_rise;
    logic bit_fall;

    assign frame_start = master_mode ? m_start : (fp_q.sync && !f_q.sync);
    assign frame_end = master_mode ? (m_tick && m_sclk_q && m_falls_q == 5'd15)
                                   : (!fp_q.sync && f_q.sync);
    assign bit_rise = master_mode ? (m_tick && !m_sclk_q)
                                  : (!f_q.sync && !fp_q.sclk && f_q.sclk);
    assign bit_fall = master_mode ? (m_tick && m_sclk_q && m_falls_q != 5'd15)
                                  : (!f_q.sync && fp_q.sclk && !f_q.sclk);

    // ==========================================================================
    // shift registers
    logic [15:0] tx_q;
    logic [4:0] rx_cnt_q;
    logic [15:0] status_word;

    assign status_word = {1'b0, BUSY || CAL_IN_PROGRESS, 13'h0000, start_bit_q} |
                         `STAT_SELECT_ONES;
    assign fifo_pop = frame_start && read_sel_q == sar_seq_pkg::RD_RESULT && fifo_out_valid;
    assign wr_done = frame_end && rx_cnt_q == 5'd16;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            tx_q <= 16'h0000;
        end else if (frame_start) begin
            case (read_sel_q)
                sar_seq_pkg::RD_RESULT: tx_q <= fifo_out_valid ? fifo_out_data : 16'h0000;
                sar_seq_pkg::RD_STATUS: tx_q <= status_word;
                sar_seq_pkg::RD_OFFSET: tx_q <= {2'b00, offset_trim_q};
                sar_seq_pkg::RD_GAIN: tx_q <= {2'b00, gain_trim_q};
                default: tx_q <= 16'h0000;
            endcase
        end else if (bit_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rx_q <= 16'h0000;
            rx_cnt_q <= 5'h00;
        end else if (frame_start) begin
            rx_cnt_q <= 5'h00;
        end else if (bit_rise) begin
            rx_q <= {rx_q[14:0], f_q.din};
            if (rx_cnt_q != 5'h1f) begin
                rx_cnt_q <= rx_cnt_q + 5'h01;
            end
        end
    end

    // ==========================================================================
    // pin drivers
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            DOUT <= 1'b0;
            SCLK_O <= 1'b0;
            SYNC_O <= 1'b1;
            SCLK_OE <= 1'b0;
            SYNC_OE <= 1'b0;
        end else begin
            DOUT <= tx_q[15];
            SCLK_O <= m_sclk_q;
            SYNC_O <= !m_active_q;
            SCLK_OE <= master_mode;
            SYNC_OE <= master_mode;
        end
    end
endmodule : sar_conversion_sequencer_cal

`default_nettype wire

// [testbench/sar_seq_monitor.sv]
// pin checker for the conversion sequencer
// assumes binding into the top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module sar_seq_monitor (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic MASTER_CLOCK_IN,
    input wire logic SERIAL_MODE_SEL_A,
    input wire logic SERIAL_MODE_SEL_B,
    input wire logic SCLK_O,
    input wire logic SCLK_OE,
    input wire logic SYNC_O,
    input wire logic SYNC_OE,
    input wire logic BUSY,
    input wire logic TRACK_HOLD
);
    // ======
    // helper counters
    logic mci_q;
    logic sclk_q;
    logic [7:0] since_q;
    logic [4:0] falls_q;
    logic [4:0] rises_q;
    wire logic mfall = mci_q & ~MASTER_CLOCK_IN;
    always_ff @(posedge MCLK) begin
        mci_q <= MASTER_CLOCK_IN;
        sclk_q <= SCLK_O;
    end
    // saturates so a stopped master clock cannot wrap into the window
    always_ff @(posedge MCLK) begin
        if (!RST_N) since_q <= 8'hff;
        else if (mfall) since_q <= 8'h00;
        else if (since_q != 8'hff) since_q <= since_q + 8'h01;
    end
    always_ff @(posedge MCLK) begin
        if (!BUSY) falls_q <= 5'h00;
        else if (mfall) falls_q <= falls_q + 5'h01;
    end
    always_ff @(posedge MCLK) begin
        if (SYNC_O) rises_q <= 5'h00;
        else if (SCLK_O && !sclk_q) rises_q <= rises_q + 5'h01;
    end
    // ======
    // assertions
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    busy_in_hold_a: assert property (BUSY |-> TRACK_HOLD)
        else $error("busy high while sampler tracks");
    end_together_a: assert property ($fell(BUSY) |-> $fell(TRACK_HOLD))
        else $error("busy and hold did not end together");
    hold_to_busy_a: assert property ($rose(TRACK_HOLD) |-> !BUSY ##[1:20] BUSY)
        else $error("hold not followed by busy");
    start_on_fall_a: assert property ($rose(BUSY) |-> since_q >= 8'h02 && since_q <= 8'h09)
        else $error("busy rose away from a master clock fall");
    conv_len_a: assert property ($fell(BUSY) |-> falls_q inside {5'h10, 5'h11})
        else $error("conversion length wrong");
    conv_max_a: assert property (BUSY |-> falls_q <= 5'h12)
        else $error("conversion longer than limit");
    frame_bits_a: assert property ($rose(SYNC_O) |-> rises_q == 5'h10)
        else $error("master frame bit count wrong");
    master_oe_a: assert property ((SERIAL_MODE_SEL_A && SERIAL_MODE_SEL_B) [*8]
        |=> SCLK_OE && SYNC_OE)
        else $error("master mode pins not driven");
    slave_oe_a: assert property ((!(SERIAL_MODE_SEL_A && SERIAL_MODE_SEL_B)) [*8]
        |=> !SCLK_OE && !SYNC_OE)
        else $error("slave mode pins driven");
    conv_done_c: cover property ($fell(BUSY));
    slow_conv_c: cover property ($fell(BUSY) && falls_q == 5'h11);
    master_frame_c: cover property ($rose(SYNC_O));
endmodule : sar_seq_monitor
bind sar_conversion_sequencer_cal sar_seq_monitor u_mon (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .MASTER_CLOCK_IN(MASTER_CLOCK_IN),
    .SERIAL_MODE_SEL_A(SERIAL_MODE_SEL_A),
    .SERIAL_MODE_SEL_B(SERIAL_MODE_SEL_B),
    .SCLK_O(SCLK_O),
    .SCLK_OE(SCLK_OE),
    .SYNC_O(SYNC_O),
    .SYNC_OE(SYNC_OE),
    .BUSY(BUSY),
    .TRACK_HOLD(TRACK_HOLD)
);
`default_nettype wire

// [testbench/host_model.sv]
// host on the serial port in slave mode
// assumes the system clock; serial clock of 160 ns, idle low
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic mclk,
    output logic sclk,
    output logic sync_n,
    output logic din,
    input wire logic dout
);
    // extra cycles with sync held low, to stretch a write
    int tail = 0;
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        din = 1'b0;
    end
    // ======
    // one 16-bit frame, msb first both ways
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        sync_n <= 1'b0;
        din <= w[15];
        repeat (8) @(posedge mclk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
            // sampled late in the high phase: dout moves only after falls
            @(negedge mclk) r[i] = dout;
            @(posedge mclk) sclk <= 1'b0;
            if (i > 0) din <= w[i-1];
            repeat (4) @(posedge mclk);
        end
        repeat (tail) @(posedge mclk);
        sync_n <= 1'b1;
        din <= ~din;
        repeat (8) @(posedge mclk);
    endtask : frame
endmodule : host_model
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the conversion sequencer
// assumes the host model beside it; master clock pin at 200 ns
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic mci = 1'b0;
    logic st_n = 1'b1;
    logic mode_a = 1'b0;
    logic mode_b = 1'b0;
    logic [11:0] code = 12'h5a3;
    logic cal = 1'b0;
    logic h_sclk, h_sync_n, h_din, sclk_o, sclk_oe, sync_o, sync_oe, dout, busy, hold;
    logic sp = 1'b0;
    logic [15:0] cap = 16'h0000;
    int mdiv = 0;
    int cyc = 0;
    int n_fail = 0;
    int num_checks = 0;
    // the pin wires: whoever enables drives
    wire logic sclk_w = sclk_oe ? sclk_o : h_sclk;
    wire logic sync_w = sync_oe ? sync_o : h_sync_n;
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        if (mdiv == 4) begin
            mdiv <= 0;
            mci <= ~mci;
        end else begin
            mdiv <= mdiv + 1;
        end
    end
    always @(posedge mclk) begin
        sp <= sclk_o;
        if (sclk_o && !sp) cap <= {cap[14:0], dout};
    end
    host_model host (.mclk(mclk), .sclk(h_sclk), .sync_n(h_sync_n), .din(h_din), .dout(dout));
    sar_conversion_sequencer_cal dut (
        .MCLK(mclk), .RST_N(rst_n), .MASTER_CLOCK_IN(mci), .CONVERSION_START_N(st_n),
        .SERIAL_MODE_SEL_A(mode_a), .SERIAL_MODE_SEL_B(mode_b), .ADC_CODE(code),
        .CAL_IN_PROGRESS(cal), .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe),
        .SYNC_I(sync_w), .SYNC_O(sync_o), .SYNC_OE(sync_oe), .DIN(h_din), .DOUT(dout),
        .BUSY(busy), .TRACK_HOLD(hold));
    // ======
    // tasks
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        num_checks++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask : chk
    task automatic xf(input logic [15:0] w, input logic [15:0] exp);
        logic [15:0] rd;
        host.frame(w, rd);
        chk(rd, exp, exp);
    endtask : xf
    task automatic wb(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 600) begin
            @(negedge mclk);
            k++;
        end
        chk({15'h0000, busy}, {15'h0000, v}, {15'h0000, v});
    endtask : wb
    task automatic conv(input logic late);
        int n;
        logic [15:0] want;
        n = 0;
        want = late ? 16'd175 : 16'd165;
        repeat (200) @(posedge mclk); // spacing of starts
        st_n <= 1'b0;
        repeat (4) @(posedge mclk);
        // release one cycle before a master clock fall, or well ahead of it
        while (!(mci && mdiv == (late ? 3 : 0))) @(posedge mclk);
        st_n <= 1'b1;
        wb(1'b1);
        while (busy === 1'b1 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        chk(16'(n), want, want); // ten cycles per master period
        wb(1'b0);
        chk({15'h0000, hold}, 16'h0000, 16'h0000);
        repeat (8) @(posedge mclk);
    endtask : conv
    function automatic logic [15:0] ctl(input logic [1:0] sel, input logic go);
        return {13'h0000, sel, go};
    endfunction : ctl
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            $display("MISMATCH t=%0t run too long", $time);
            end_of_test();
        end
    end
    // ======
    // tests; one status read lands inside a conversion on purpose
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (50) @(posedge mclk); // settling wait before use
        xf(ctl(2'h2, 1'b0), 16'h0000);
        xf(ctl(2'h3, 1'b0), 16'h2000);
        cal <= 1'b1;
        xf(ctl(2'h1, 1'b0), 16'h2000);
        xf(ctl(2'h0, 1'b0), 16'h40c0);
        cal <= 1'b0;
        $display("reset values done");
        conv(1'b0);
        xf(ctl(2'h0, 1'b1), {4'h0, code});
        wb(1'b1);
        wb(1'b0);
        repeat (200) @(posedge mclk);
        xf(ctl(2'h1, 1'b1), {4'h0, code});
        wb(1'b1);
        // status read mid-conversion; the write then ends after the busy fall
        host.tail = 60;
        xf(ctl(2'h1, 1'b1), 16'h40c1);
        host.tail = 0;
        wb(1'b1);
        wb(1'b0);
        xf(ctl(2'h0, 1'b0), 16'h00c0);
        xf(ctl(2'h0, 1'b0), {4'h0, code});
        xf(ctl(2'h0, 1'b0), {4'h0, code});
        $display("start paths done");
        // 2048 offset steps of 819/2^15 codes each: 51.19 codes
        xf({2'b01, 14'h2800}, 16'h0000);
        conv(1'b0);
        xf(ctl(2'h2, 1'b0), {4'h0, code + 12'd51});
        xf(ctl(2'h0, 1'b0), 16'h2800);
        xf({2'b01, 14'h1800}, 16'h0000);
        conv(1'b1); // missed setup
        // a negative step rounds down: -51.19 becomes -52
        xf(ctl(2'h0, 1'b0), {4'h0, code - 12'd52});
        xf(ctl(2'h0, 1'b0), 16'h0000);
        xf({2'b01, 14'h2000}, 16'h0000);
        xf({2'b10, 14'h2800}, 16'h0000);
        conv(1'b0);
        // 1443 * 2048 * 819 / 2^28 = 9.02 codes
        xf(ctl(2'h3, 1'b0), {4'h0, code + 12'd9});
        xf(ctl(2'h0, 1'b0), 16'h2800);
        $display("trim done");
        mode_a <= 1'b1;
        mode_b <= 1'b1;
        conv(1'b0);
        repeat (300) @(posedge mclk);
        // gain trim is still raised from the step before
        chk(cap, {4'h0, code + 12'd9}, {4'h0, code + 12'd9});
        chk({15'h0000, sclk_oe}, 16'h0001, 16'h0001);
        $display("master frame done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
